// >>> hw/programmable_digital_cell.sv
`timescale 1ns/1ps
module programmable_digital_cell
  import pdc_pkg::*;
(
  input  wire logic                  clk_sys,     // Cell clock, 20 MHz.
  input  wire logic                  sys_rst,     // Synchronous reset, active high.
  input  wire logic [NUM_IN-1:0]     route_in_a,  // Fabric inputs to array A.
  input  wire logic [TERM_CFG_W-1:0] term_use_a,  // Array A term input use.
  input  wire logic [TERM_CFG_W-1:0] term_inv_a,  // Array A term input polarity.
  input  wire logic [SUM_CFG_W-1:0]  sum_sel_a,   // Array A term selection per output.
  input  wire logic [NUM_OUT-1:0]    out_reg_a,   // Array A registered output choice.
  input  wire logic [NUM_IN-1:0]     route_in_b,  // Fabric inputs to array B.
  input  wire logic [TERM_CFG_W-1:0] term_use_b,  // Array B term input use.
  input  wire logic [TERM_CFG_W-1:0] term_inv_b,  // Array B term input polarity.
  input  wire logic [SUM_CFG_W-1:0]  sum_sel_b,   // Array B term selection per output.
  input  wire logic [NUM_OUT-1:0]    out_reg_b,   // Array B registered output choice.
  input  wire logic [DP_WIDTH-1:0]   data_in,     // Parallel data into the datapath.
  output logic      [NUM_OUT-1:0]    pld_out_a,   // Array A outputs to the fabric.
  output logic      [NUM_OUT-1:0]    pld_out_b,   // Array B outputs to the fabric.
  output logic      [DP_WIDTH-1:0]   acc_out,     // Accumulator value.
  output logic                       cmp_eq,      // Accumulator equals data register.
  output logic                       cmp_lt,      // Accumulator below data register.
  output logic                       zero_det,    // Accumulator is all zeros.
  output logic                       ones_det,    // Accumulator is all ones.
  output logic                       carry_out    // Carry or borrow of last update.
);

  // The two arrays are built from one module with separate settings.
  // Their outputs leave the cell directly because a combinational
  // setting must not gain a cycle of delay at the cell boundary.

  // Array A drives the datapath function and accumulator write.
  twelve_input_four_output_array u_array_a (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .array_in  (route_in_a),
    .term_use  (term_use_a),
    .term_inv  (term_inv_a),
    .sum_sel   (sum_sel_a),
    .out_reg   (out_reg_a),
    .array_out (pld_out_a)
  );

  // Array B drives the data register load and the operand choice.
  twelve_input_four_output_array u_array_b (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .array_in  (route_in_b),
    .term_use  (term_use_b),
    .term_inv  (term_inv_b),
    .sum_sel   (sum_sel_b),
    .out_reg   (out_reg_b),
    .array_out (pld_out_b)
  );

  // Datapath state.
  logic [DP_WIDTH-1:0] acc;        // Accumulator.
  logic [DP_WIDTH-1:0] dreg;       // Data register.
  logic                carry;      // Carry from the last accumulator write.

  // Datapath control decoded from the array outputs.
  alu_op_e             alu_op;     // Function for this cycle.
  wire                 acc_we;     // Accumulator takes the result.
  wire                 dreg_we;    // Data register takes data_in.
  wire                 use_din;    // Second operand is data_in, not dreg.
  wire [DP_WIDTH-1:0]  operand;    // Second operand of the unit.
  wire [DP_WIDTH:0]    sum_ext;    // Add with carry bit.
  wire [DP_WIDTH:0]    diff_ext;   // Subtract with borrow bit.
  wire [DP_WIDTH:0]    inc_ext;    // Increment with carry bit.
  wire [DP_WIDTH:0]    dec_ext;    // Decrement with borrow bit.
  logic [DP_WIDTH:0]   next_acc;   // Result with carry in the top bit.

  // The function can change every cycle, so the arrays act as sequencer.
  assign alu_op   = alu_op_e'(pld_out_a[2:0]);
  assign acc_we   = pld_out_a[3];
  assign dreg_we  = pld_out_b[0];
  assign use_din  = pld_out_b[1];
  assign operand  = use_din ? data_in : dreg;

  // Arithmetic carries are kept in a ninth bit.
  assign sum_ext  = {1'b0, acc} + {1'b0, operand};
  assign diff_ext = {1'b0, acc} - {1'b0, operand};
  assign inc_ext  = {1'b0, acc} + {1'b0, STEP_VAL};
  assign dec_ext  = {1'b0, acc} - {1'b0, STEP_VAL};

  // Function select for the arithmetic unit.
  always_comb
  begin
    next_acc = {1'b0, acc};
    unique case (alu_op)
      ALU_PASS: next_acc = {1'b0, operand};
      ALU_INC:  next_acc = inc_ext;
      ALU_DEC:  next_acc = dec_ext;
      ALU_ADD:  next_acc = sum_ext;
      ALU_SUB:  next_acc = diff_ext;
      ALU_AND:  next_acc = {1'b0, acc & operand};
      ALU_OR:   next_acc = {1'b0, acc | operand};
      ALU_XOR:  next_acc = {1'b0, acc ^ operand};
    endcase
  end

  // Accumulator and carry update only when array A asks for it.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      acc   <= DATA_RST;
      carry <= 1'b0;
    end
    else if (acc_we)
    begin
      acc   <= next_acc[DP_WIDTH-1:0];
      carry <= next_acc[DP_WIDTH];
    end
  end

  // Data register loads the parallel input under array B.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      dreg <= DATA_RST;
    else if (dreg_we)
      dreg <= data_in;
  end

  // A load takes the parallel input seen at the same edge.
  property p_dreg_load;
    @(posedge clk_sys) disable iff (sys_rst)
      dreg_we |=> dreg == $past(data_in);
  endproperty
  a_dreg_load: assert property (p_dreg_load) else $error("data load wrong");

  // Condition logic compares the accumulator with the data register, with all zeros and with all ones.
  wire cond_eq   = (acc == dreg);
  wire cond_lt   = (acc < dreg);
  wire cond_zero = (acc == DATA_RST);
  wire cond_ones = (acc == ONES_VAL);

  // Conditions are registered so every datapath output of the cell comes from a flop.
  // The trade-off is one cycle of lag behind the accumulator.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cmp_eq    <= 1'b0;
      cmp_lt    <= 1'b0;
      zero_det  <= 1'b0;
      ones_det  <= 1'b0;
      carry_out <= 1'b0;
      acc_out   <= DATA_RST;
    end
    else
    begin
      cmp_eq    <= cond_eq;
      cmp_lt    <= cond_lt;
      zero_det  <= cond_zero;
      ones_det  <= cond_ones;
      carry_out <= carry;
      acc_out   <= acc;
    end
  end

  // acc_out and carry_out are exact one-cycle copies of the accumulator and carry.
  property p_out_copy;
    @(posedge clk_sys) disable iff (sys_rst)
      1'b1 |=> acc_out == $past(acc) && carry_out == $past(carry);
  endproperty
  a_out_copy: assert property (p_out_copy) else $error("output copy wrong");

  // Two back-to-back increments raise the accumulator by two.
  sequence s_inc_twice;
    (acc_we && alu_op == ALU_INC) [*2];
  endsequence
  property p_inc_twice;
    @(posedge clk_sys) disable iff (sys_rst)
      s_inc_twice |=> acc == $past(acc, 2) + 8'h02;
  endproperty
  a_inc_twice: assert property (p_inc_twice) else $error("double increment wrong");

  // A subtract writes the difference and its borrow.
  property p_sub;
    @(posedge clk_sys) disable iff (sys_rst)
      (acc_we && alu_op == ALU_SUB) |=> {carry, acc} == $past(diff_ext);
  endproperty
  a_sub: assert property (p_sub) else $error("subtract result wrong");

  // A pass loads the operand and clears the carry.
  property p_pass;
    @(posedge clk_sys) disable iff (sys_rst)
      (acc_we && alu_op == ALU_PASS) |=> acc == $past(operand) && !carry;
  endproperty
  a_pass: assert property (p_pass) else $error("pass result wrong");

  // Accumulator holds while array A keeps the write off.
  property p_acc_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      !acc_we |=> $stable(acc);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved without write");

  // Equal flag shows the compare one cycle later.
  property p_eq_flag;
    @(posedge clk_sys) disable iff (sys_rst)
      (acc == dreg) |=> cmp_eq && !cmp_lt;
  endproperty
  a_eq_flag: assert property (p_eq_flag) else $error("equal compare wrong");

  // Zero detect follows a loaded zero within two cycles.
  property p_zero;
    @(posedge clk_sys) disable iff (sys_rst)
      (acc_we && alu_op == ALU_PASS && operand == DATA_RST) |-> ##2 zero_det;
  endproperty
  a_zero: assert property (p_zero) else $error("zero detect missed");

endmodule

// >>> hw/twelve_input_four_output_array.sv
`timescale 1ns/1ps
module twelve_input_four_output_array
  import pdc_pkg::*;
(
  input  wire logic                  clk_sys,   // Cell clock.
  input  wire logic                  sys_rst,   // Synchronous reset, active high.
  input  wire logic [NUM_IN-1:0]     array_in,  // Inputs from the routing fabric.
  input  wire logic [TERM_CFG_W-1:0] term_use,  // Input used by a term, 12 bits per term.
  input  wire logic [TERM_CFG_W-1:0] term_inv,  // Input complemented in a term.
  input  wire logic [SUM_CFG_W-1:0]  sum_sel,   // Terms summed, 8 bits per output.
  input  wire logic [NUM_OUT-1:0]    out_reg,   // Output taken from the state register.
  output logic      [NUM_OUT-1:0]    array_out  // Sum-of-products outputs.
);

  logic [NUM_PT-1:0]  term;   // Product term results.
  logic [NUM_OUT-1:0] sum;    // Sum results before the output choice.
  logic [NUM_OUT-1:0] state;  // Registered state bits.

  // Every term sees all twelve inputs, so input positions are interchangeable.
  // An unused input forces its lane to one and drops out of the AND.
  // A term with no input selected reads as constant one, which holds high any output that selects it.
  genvar p;
  generate
    for (p = 0; p < NUM_PT; p++)
    begin : g_term
      wire [NUM_IN-1:0] lit = array_in ^ term_inv[p*NUM_IN +: NUM_IN];
      assign term[p] = &(~term_use[p*NUM_IN +: NUM_IN] | lit);
    end
  endgenerate

  // Each output has an OR of full width eight over all terms.
  genvar o;
  generate
    for (o = 0; o < NUM_OUT; o++)
    begin : g_sum
      assign sum[o] = |(term & sum_sel[o*NUM_PT +: NUM_PT]);
      assign array_out[o] = out_reg[o] ? state[o] : sum[o];
    end
  endgenerate

  // State bits capture every sum each edge and clear under reset.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      state <= STATE_RST;
    else
      state <= sum;
  end

  // Registered output shows last cycle's sum.
  // The edge after reset is skipped, since reset cleared the state rather than load the sum.
  property p_reg_out;
    @(posedge clk_sys) disable iff (sys_rst)
      (out_reg[0] && $stable(out_reg[0]) && !$past(sys_rst)) |-> array_out[0] == $past(sum[0]);
  endproperty
  a_reg_out: assert property (p_reg_out) else $error("registered output lags wrong");

  // Combinational output follows the sum at once.
  property p_comb_out;
    @(posedge clk_sys) disable iff (sys_rst)
      !out_reg[3] |-> array_out[3] == sum[3];
  endproperty
  a_comb_out: assert property (p_comb_out) else $error("combinational output wrong");

  // A selected term that is true forces the output sum high.
  property p_or_term;
    @(posedge clk_sys) disable iff (sys_rst)
      (term[7] && sum_sel[2*NUM_PT+7]) |-> sum[2];
  endproperty
  a_or_term: assert property (p_or_term) else $error("sum missed a true term");

  // A term using only input zero follows that input's chosen polarity.
  property p_term_lit;
    @(posedge clk_sys) disable iff (sys_rst)
      (term_use[NUM_IN-1:0] == 12'h001) |-> term[0] == (array_in[0] ^ term_inv[0]);
  endproperty
  a_term_lit: assert property (p_term_lit) else $error("term polarity wrong");

  // State clears on the edge that samples reset.
  property p_rst_clr;
    @(posedge clk_sys) sys_rst |=> state == STATE_RST;
  endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("state not cleared by reset");

endmodule

// >>> pkg/pdc_pkg.sv
package pdc_pkg;

  // Array geometry: inputs, product terms and outputs per array.
  localparam int NUM_IN = 12;
  localparam int NUM_PT = 8;
  localparam int NUM_OUT = 4;

  // Each programmable digital cell holds this many arrays.
  localparam int NUM_ARRAYS = 2;

  // Width of the neighbouring datapath.
  localparam int DP_WIDTH = 8;

  // Flattened configuration widths.
  localparam int TERM_CFG_W = NUM_IN * NUM_PT;
  localparam int SUM_CFG_W = NUM_PT * NUM_OUT;

  // Values after reset, the all-ones compare value and the increment step.
  localparam logic [NUM_OUT-1:0] STATE_RST = 4'h0;
  localparam logic [DP_WIDTH-1:0] DATA_RST = 8'h00;
  localparam logic [DP_WIDTH-1:0] ONES_VAL = 8'hff;
  localparam logic [DP_WIDTH-1:0] STEP_VAL = 8'h01;

  // Datapath arithmetic unit functions, chosen every cycle.
  typedef enum logic [2:0] {
    ALU_PASS = 3'b000,
    ALU_INC  = 3'b001,
    ALU_DEC  = 3'b010,
    ALU_ADD  = 3'b011,
    ALU_SUB  = 3'b100,
    ALU_AND  = 3'b101,
    ALU_OR   = 3'b110,
    ALU_XOR  = 3'b111
  } alu_op_e;

endpackage

// >>> test/fabric_model.sv
`timescale 1ns/1ps
// Stands in for the routing fabric in front of both arrays.
// Patterns change only at the falling edge, well clear of the sampling edge.
module fabric_model
  import pdc_pkg::*;
(
  input  wire logic              clk_sys,     // Cell clock.
  input  wire logic [NUM_IN-1:0] want_a,      // Pattern wanted on array A.
  input  wire logic [NUM_IN-1:0] want_b,      // Pattern wanted on array B.
  output logic      [NUM_IN-1:0] route_in_a,  // Fabric inputs to array A.
  output logic      [NUM_IN-1:0] route_in_b   // Fabric inputs to array B.
);
  // Both buses start low so the cell never sees an unknown input.
  initial
  begin
    route_in_a = 12'h000;
    route_in_b = 12'h000;
  end

  // Launch the wanted patterns, all twelve lines at once.
  always @(negedge clk_sys)
  begin
    route_in_a <= want_a;
    route_in_b <= want_b;
  end
endmodule

// >>> test/programmable_digital_cell_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the cell: arrays first, then the datapath they steer.
module programmable_digital_cell_bench;
  import pdc_pkg::*;
  logic                  clk_sys = 1'b0;           // Cell clock, 50 ns period.
  logic                  sys_rst = 1'b1;           // Synchronous reset.
  logic [NUM_IN-1:0]     want_a = 12'h000;         // Fabric pattern for A.
  logic [NUM_IN-1:0]     want_b = 12'h000;         // Fabric pattern for B.
  logic [NUM_IN-1:0]     route_in_a;               // From the fabric model.
  logic [NUM_IN-1:0]     route_in_b;               // From the fabric model.
  logic [TERM_CFG_W-1:0] term_use_a = 96'h0;       // Array A term use.
  logic [TERM_CFG_W-1:0] term_inv_a = 96'h0;       // Array A polarity.
  logic [SUM_CFG_W-1:0]  sum_sel_a = 32'h0;        // Array A sums.
  logic [NUM_OUT-1:0]    out_reg_a = 4'h0;         // Array A register choice.
  logic [TERM_CFG_W-1:0] term_use_b = 96'h0;       // Array B term use.
  logic [TERM_CFG_W-1:0] term_inv_b = 96'h0;       // Array B polarity.
  logic [SUM_CFG_W-1:0]  sum_sel_b = 32'h0;        // Array B sums.
  logic [NUM_OUT-1:0]    out_reg_b = 4'h0;         // Array B register choice.
  logic [DP_WIDTH-1:0]   data_in = 8'h00;          // Datapath parallel input.
  logic [NUM_OUT-1:0]    pld_out_a;                // Array A outputs.
  logic [NUM_OUT-1:0]    pld_out_b;                // Array B outputs.
  logic [DP_WIDTH-1:0]   acc_out;                  // Accumulator.
  logic                  cmp_eq;                   // Equal flag.
  logic                  cmp_lt;                   // Below flag.
  logic                  zero_det;                 // Zero flag.
  logic                  ones_det;                 // Ones flag.
  logic                  carry_out;                // Carry flag.
  int                    num_errors = 0;           // Mismatches seen.
  int                    num_checks = 0;           // Comparisons made.
  int                    cycles = 0;               // Cycles run, for the timeout.

  // The clock toggles every half period.
  always #25 clk_sys = ~clk_sys;

  fabric_model i_fabric (.clk_sys(clk_sys), .want_a(want_a), .want_b(want_b),
    .route_in_a(route_in_a), .route_in_b(route_in_b));

  programmable_digital_cell i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .route_in_a(route_in_a), .term_use_a(term_use_a), .term_inv_a(term_inv_a),
    .sum_sel_a(sum_sel_a), .out_reg_a(out_reg_a), .route_in_b(route_in_b),
    .term_use_b(term_use_b), .term_inv_b(term_inv_b), .sum_sel_b(sum_sel_b),
    .out_reg_b(out_reg_b), .data_in(data_in), .pld_out_a(pld_out_a),
    .pld_out_b(pld_out_b), .acc_out(acc_out), .cmp_eq(cmp_eq), .cmp_lt(cmp_lt),
    .zero_det(zero_det), .ones_det(ones_det), .carry_out(carry_out));

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Checks made %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // The whole run needs far fewer cycles; a hang stops here.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      stop_test();
    end
  end

  // One comparison; case inequality so an unknown never matches.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds reset for five cycles, checks cleared outputs, releases at a falling edge.
  task automatic do_reset();
    @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    check("acc_out in reset", 8'h00, acc_out);
    check("registered out in reset", {4'h0, 4'h0}, {4'h0, pld_out_a & out_reg_a});
    sys_rst = 1'b0;
  endtask

  // Shows a pattern to array B and waits until it has settled.
  task automatic show_b(input logic [NUM_IN-1:0] pat);
    @(posedge clk_sys);
    want_b = pat;
    @(negedge clk_sys);
    #5;
  endtask

  // Shows a pattern to array A and waits until it has settled.
  task automatic show_a(input logic [NUM_IN-1:0] pat);
    @(posedge clk_sys);
    want_a = pat;
    @(negedge clk_sys);
    #5;
  endtask

  // One datapath step: function and data for one edge, then hold and read the copy.
  task automatic alu_step(input logic [3:0] pat, input logic [7:0] din, input logic [8:0] exp);
    show_a({8'h00, pat});
    data_in = din;
    show_a(12'h000);
    @(posedge clk_sys);
    #5;
    check("acc_out after step", exp[7:0], acc_out);
    check("carry_out after step", {7'h0, exp[8]}, {7'h0, carry_out});
  endtask

  // Term 0 of B uses one input inverted; output 0 is low only when that input is high.
  task automatic test_polarity();
    sum_sel_b = 32'h00000001;
    for (int i = 0; i < NUM_IN; i++)
    begin
      term_use_b = 96'h1 << i;
      term_inv_b = 96'h1 << i;
      show_b(12'h001 << i);
      check("inverted input high", 8'h00, {7'h0, pld_out_b[0]});
      show_b(~(12'h001 << i));
      check("others ignored", 8'h01, {7'h0, pld_out_b[0]});
    end
    $display("Test polarity done");
  endtask

  // Term p takes input p true; output 3 sums all eight, output 2 only term 7.
  task automatic test_sum();
    term_inv_b = 96'h0;
    term_use_b = 96'h0;
    for (int p = 0; p < NUM_PT; p++)
      term_use_b[p*NUM_IN+p] = 1'b1;
    sum_sel_b = 32'hff800000;
    show_b(12'h000);
    check("sum all low", 8'h00, {4'h0, pld_out_b});
    for (int p = 0; p < NUM_PT; p++)
    begin
      show_b(12'h001 << p);
      check("sum one term", (p == 7) ? 8'h0c : 8'h08, {4'h0, pld_out_b});
    end
    $display("Test sum done");
  endtask

  // Registered outputs on A: increment with write enable, counted after reset.
  task automatic test_registered();
    sum_sel_a = 32'h01000001;
    out_reg_a = 4'h9;
    do_reset();
    @(posedge clk_sys);
    #5;
    check("registered out after edge", 8'h09, {4'h0, pld_out_a});
    repeat (2) @(posedge clk_sys);
    #5;
    check("acc_out after inc", 8'h01, acc_out);
    check("zero flag", 8'h00, {7'h0, zero_det});
    $display("Test registered done");
  endtask

  // Combinational decrement from zero wraps with a borrow.
  task automatic test_decrement();
    sum_sel_a = 32'h01000100;
    out_reg_a = 4'h0;
    do_reset();
    check("comb out in reset", 8'h0a, {4'h0, pld_out_a});
    repeat (2) @(posedge clk_sys);
    #5;
    check("acc_out after dec", 8'hff, acc_out);
    check("borrow and ones", 8'h03, {6'h0, carry_out, ones_det});
    check("array B kept apart", 8'h0c, {4'h0, pld_out_b});
    $display("Test decrement done");
  endtask

  // Output o of A follows input o, so want_a carries {write, function}; B loads and picks data_in.
  task automatic test_alu();
    term_inv_a = 96'h0;
    term_use_a = 96'h80_0400_2001;
    sum_sel_a  = 32'h08040201;
    out_reg_a  = 4'h0;
    term_use_b = 96'h0;
    sum_sel_b  = 32'h00000202;
    do_reset();
    alu_step(4'h8, 8'h00, 9'h000);
    check("zero flag after pass", 8'h01, {7'h0, zero_det});
    check("compare after pass", 8'h02, {6'h0, cmp_eq, cmp_lt});
    alu_step(4'h8, 8'h5c, 9'h05c);
    alu_step(4'hb, 8'hc0, 9'h11c);
    alu_step(4'hd, 8'h3c, 9'h01c);
    check("compare after and", 8'h01, {6'h0, cmp_eq, cmp_lt});
    alu_step(4'he, 8'h41, 9'h05d);
    alu_step(4'hf, 8'hff, 9'h0a2);
    alu_step(4'hc, 8'ha3, 9'h1ff);
    check("ones flag after sub", 8'h01, {7'h0, ones_det});
    $display("Test alu done");
  endtask

  // Main sequence.
  initial
  begin
    do_reset();
    test_polarity();
    test_sum();
    test_registered();
    test_decrement();
    test_alu();
    stop_test();
  end
endmodule
